// file: hdl/lcc_top.sv
// Logic cell with its control register, bus slave and interrupt
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "lcc_cfg.svh"

module lcc_top
(
    input  wire logic       I_CLK_SYS,
    input  wire logic       I_RST_B,
    input  wire logic [3:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    input  wire logic [3:0] I_GATE,
    output logic      [7:0] O_RDATA,
    output logic            O_CELL_OUT,
    output logic            O_IRQ
);

    // ==========================================================
    // Bus request bundle
    lcc_pkg::lcc_bus_req_t req;
    assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

    // ==========================================================
    // Control register
    lcc_pkg::lcc_ctrl_t ctrl;
    logic               wr_ctrl;
    assign wr_ctrl = req.wr && (req.addr == `LCC_OFF_CTRL);

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
        begin
            ctrl <= '0;
        end
        else if (wr_ctrl)
        begin
            ctrl.cell_enable          <= req.wdata[`LCC_BIT_EN];
            ctrl.rise_irq_enable      <= req.wdata[`LCC_BIT_RISE_IE];
            ctrl.fall_irq_enable      <= req.wdata[`LCC_BIT_FALL_IE];
            ctrl.cell_function_select <=
                req.wdata[`LCC_MODE_HI:`LCC_MODE_LO];
        end
    end

    // ==========================================================
    // Output polarity, not cleared by reset
    logic output_invert;

    always_ff @(posedge I_CLK_SYS)
    begin
        if (req.wr && (req.addr == `LCC_OFF_POLARITY))
        begin
            output_invert <= req.wdata[0];
        end
    end

    // ==========================================================
    // Logic function stage
    logic seq_q;
    logic next_seq;
    logic comb_val;

    always_comb
    begin
        next_seq = seq_q;
        comb_val = 1'b0;
        case (ctrl.cell_function_select)
            `LCC_MODE_AND_OR:
                comb_val = (I_GATE[0] & I_GATE[1]) |
                           (I_GATE[2] & I_GATE[3]);
            `LCC_MODE_OR_XOR:
                comb_val = (I_GATE[0] | I_GATE[1]) ^
                           (I_GATE[2] | I_GATE[3]);
            `LCC_MODE_AND4:
                comb_val = &I_GATE;
            `LCC_MODE_SR:
            begin
                if (I_GATE[2] | I_GATE[3])
                    next_seq = 1'b0;
                else if (I_GATE[0] | I_GATE[1])
                    next_seq = 1'b1;
            end
            `LCC_MODE_DFF_SR:
            begin
                if (I_GATE[2])
                    next_seq = 1'b0;
                else if (I_GATE[3])
                    next_seq = 1'b1;
                else
                    next_seq = I_GATE[1];
            end
            `LCC_MODE_DFF_R:
                next_seq = I_GATE[2] ? 1'b0 : (I_GATE[1] & I_GATE[3]);
            `LCC_MODE_JK_R:
            begin
                if (I_GATE[2])
                    next_seq = 1'b0;
                else
                    next_seq = (I_GATE[1] & ~seq_q) |
                               (~I_GATE[3] & seq_q);
            end
            `LCC_MODE_LATCH:
            begin
                if (I_GATE[2])
                    next_seq = 1'b0;
                else if (I_GATE[3])
                    next_seq = 1'b1;
                else if (I_GATE[0])
                    next_seq = I_GATE[1];
            end
            default:
                comb_val = 1'b0;
        endcase
    end

    logic is_seq;
    assign is_seq = (ctrl.cell_function_select == `LCC_MODE_SR)
                 || (ctrl.cell_function_select[2] == 1'b1);

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B || !ctrl.cell_enable)
            seq_q <= 1'b0;
        else
            seq_q <= next_seq;
    end

    // ==========================================================
    // Output after polarity, sampled each clock
    logic cell_output_signal;
    logic cell_output_status;
    logic cell_raw;
    assign cell_raw = is_seq ? seq_q : comb_val;

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
            cell_output_signal <= 1'b0;
        else if (!ctrl.cell_enable)
            cell_output_signal <= 1'b0;
        else
            cell_output_signal <= cell_raw ^ output_invert;
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
            cell_output_status <= 1'b0;
        else
            cell_output_status <= cell_output_signal;
    end

    assign O_CELL_OUT = cell_output_signal;

    // ==========================================================
    // Edge detection and interrupt status
    logic [`LCC_IRQ_W-1:0] irq_status;
    logic [`LCC_IRQ_W-1:0] irq_mask;
    logic [`LCC_IRQ_W-1:0] edge_hit;
    logic [`LCC_IRQ_W-1:0] clr_bits;

    assign edge_hit[`LCC_IRQ_RISE] = ctrl.rise_irq_enable &
        cell_output_signal & ~cell_output_status;
    assign edge_hit[`LCC_IRQ_FALL] = ctrl.fall_irq_enable &
        ~cell_output_signal & cell_output_status;
    assign clr_bits = (req.wr && (req.addr == `LCC_OFF_IRQ_STATUS)) ?
        req.wdata[`LCC_IRQ_W-1:0] : '0;

    generate
        for (genvar i = 0; i < `LCC_IRQ_W; i++)
        begin : g_irq
            always_ff @(posedge I_CLK_SYS)
            begin
                if (!I_RST_B)
                    irq_status[i] <= 1'b0;
                else if (edge_hit[i])
                    irq_status[i] <= 1'b1;
                else if (clr_bits[i])
                    irq_status[i] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
            irq_mask <= '0;
        else if (req.wr && (req.addr == `LCC_OFF_IRQ_MASK))
            irq_mask <= req.wdata[`LCC_IRQ_W-1:0];
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
            O_IRQ <= 1'b0;
        else
            O_IRQ <= |(irq_status & irq_mask);
    end

    // ==========================================================
    // Read data
    logic [7:0] next_rdata;

    always_comb
    begin
        next_rdata = 8'h00;
        case (req.addr)
            `LCC_OFF_CTRL:
            begin
                next_rdata[`LCC_BIT_EN]      = ctrl.cell_enable;
                next_rdata[`LCC_BIT_UNUSED]  = 1'b0;
                next_rdata[`LCC_BIT_OUT]     = cell_output_status;
                next_rdata[`LCC_BIT_RISE_IE] = ctrl.rise_irq_enable;
                next_rdata[`LCC_BIT_FALL_IE] = ctrl.fall_irq_enable;
                next_rdata[`LCC_MODE_HI:`LCC_MODE_LO] =
                    ctrl.cell_function_select;
            end
            `LCC_OFF_IRQ_STATUS: next_rdata[`LCC_IRQ_W-1:0] = irq_status;
            `LCC_OFF_IRQ_MASK:   next_rdata[`LCC_IRQ_W-1:0] = irq_mask;
            `LCC_OFF_CELL_IN:    next_rdata[3:0] = I_GATE;
            `LCC_OFF_POLARITY:   next_rdata[0] = output_invert;
            default:             next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
            O_RDATA <= 8'h00;
        else if (req.rd)
            O_RDATA <= next_rdata;
        else
            O_RDATA <= 8'h00;
    end

endmodule

// file: inc/lcc_cfg.svh
// Constants for the logic cell control register block
`ifndef LCC_CFG_SVH
`define LCC_CFG_SVH

// ==========================================================
// Register map
`define LCC_ADDR_W          4
`define LCC_OFF_CTRL        4'h0
`define LCC_OFF_IRQ_STATUS  4'h1
`define LCC_OFF_IRQ_MASK    4'h2
`define LCC_OFF_CELL_IN     4'h3
`define LCC_OFF_POLARITY    4'h4

// ==========================================================
// Control register fields
`define LCC_BIT_EN          7
`define LCC_BIT_UNUSED      6
`define LCC_BIT_OUT         5
`define LCC_BIT_RISE_IE     4
`define LCC_BIT_FALL_IE     3
`define LCC_MODE_HI         2
`define LCC_MODE_LO         0
`define LCC_CTRL_WMASK      8'h9F
`define LCC_CTRL_RESET      8'h00

// ==========================================================
// Function select codes
`define LCC_MODE_AND_OR     3'h0
`define LCC_MODE_OR_XOR     3'h1
`define LCC_MODE_AND4       3'h2
`define LCC_MODE_SR         3'h3
`define LCC_MODE_DFF_SR     3'h4
`define LCC_MODE_DFF_R      3'h5
`define LCC_MODE_JK_R       3'h6
`define LCC_MODE_LATCH      3'h7

// ==========================================================
// Interrupt status bits
`define LCC_IRQ_W           2
`define LCC_IRQ_RISE        0
`define LCC_IRQ_FALL        1

`endif

// file: inc/lcc_pkg.sv
// Types for the logic cell control register block
package lcc_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lcc_bus_req_t;

    typedef struct packed {
        logic       cell_enable;
        logic       rise_irq_enable;
        logic       fall_irq_enable;
        logic [2:0] cell_function_select;
    } lcc_ctrl_t;

endpackage

// file: tb/lcc_checker.sv
// Port assertions for the logic cell control block
`timescale 1ns/10ps
module lcc_checker
(
    input wire logic       I_CLK_SYS,
    input wire logic       I_RST_B,
    input wire logic [3:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic       I_WR,
    input wire logic       I_RD,
    input wire logic [3:0] I_GATE,
    input wire logic [7:0] O_RDATA,
    input wire logic       O_CELL_OUT,
    input wire logic       O_IRQ
);
    logic [7:0] ctrl_q;
    logic [1:0] mask_q;
    logic       pol_q;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_B);
    // ==========================================================
    // Shadows of written settings
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_B)
        begin
            ctrl_q <= 8'h00;
            mask_q <= 2'h0;
        end
        else if (I_WR && I_ADDR == 4'h0)
            ctrl_q <= I_WDATA & 8'h9F;
        else if (I_WR && I_ADDR == 4'h2)
            mask_q <= I_WDATA[1:0];
    end
    // Polarity survives reset
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_WR && I_ADDR == 4'h4)
            pol_q <= I_WDATA[0];
    end
    // ==========================================================
    // Properties
    a_off_zero: assert property (!$past(ctrl_q[7]) |-> !O_CELL_OUT)
        else $error("cell output high while off");
    a_bit6_zero: assert property ($past(I_RD) && $past(I_ADDR) == 4'h0
        |-> !O_RDATA[6]) else $error("bit six read high");
    a_status_bit: assert property ($past(I_RD)
        && $past(I_ADDR) == 4'h0
        && $stable(O_CELL_OUT) && $past(O_CELL_OUT, 2) == O_CELL_OUT
        |-> O_RDATA[5] == O_CELL_OUT) else $error("status bit wrong");
    a_reset_clear: assert property ($rose(I_RST_B)
        |-> O_RDATA == 8'h00 && !O_CELL_OUT && !O_IRQ)
        else $error("outputs not cleared");
    a_rise_irq: assert property ($rose(O_CELL_OUT) && ctrl_q[4]
        && mask_q[0] |-> ##[1:3] O_IRQ) else $error("rise irq missing");
    a_fall_irq: assert property ($fell(O_CELL_OUT) && ctrl_q[3]
        && mask_q[1] |-> ##[1:3] O_IRQ) else $error("fall irq missing");
    a_mask_quiet: assert property ($past(mask_q) == 2'h0 |-> !O_IRQ)
        else $error("masked irq high");
    a_andor_mode: assert property ($past(ctrl_q[7])
        && $past(ctrl_q[2:0]) == 3'h0 |-> O_CELL_OUT == ($past(pol_q)
        ^ (($past(I_GATE[0]) & $past(I_GATE[1]))
        | ($past(I_GATE[2]) & $past(I_GATE[3]))))) else $error("and-or bad");
    a_and4_mode: assert property ($past(ctrl_q[7])
        && $past(ctrl_q[2:0]) == 3'h2 |-> O_CELL_OUT
        == ((&$past(I_GATE)) ^ $past(pol_q))) else $error("and4 bad");
endmodule

bind lcc_top lcc_checker u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .I_GATE(I_GATE), .O_RDATA(O_RDATA), .O_CELL_OUT(O_CELL_OUT),
    .O_IRQ(O_IRQ));

// file: tb/lcc_testbench.sv
// Self-checking bench for the logic cell control block
`timescale 1ns/10ps
`define TB_CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
    logic       clk;
    logic       rst_b;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [3:0] gate;
    logic [7:0] rdata;
    logic       cell_out;
    logic       irq;
    logic [7:0] d;
    logic       pol;
    logic       st;
    int         n_fail;
    int         compares;
    lcc_top dut (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_GATE(gate),
        .O_RDATA(rdata), .O_CELL_OUT(cell_out), .O_IRQ(irq));
    // ==========================================================
    // Bus and gate drivers
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic settle(input logic [3:0] g);
        @(posedge clk);
        gate <= g;
        repeat (5) @(posedge clk);
        #1;
    endtask
    function automatic logic exp_out(input logic [2:0] m,
                                     input logic [3:0] g, input logic p);
        case (m)
            3'h0:    return ((g[0] & g[1]) | (g[2] & g[3])) ^ p;
            3'h1:    return ((g[0] | g[1]) ^ (g[2] | g[3])) ^ p;
            default: return (&g) ^ p;
        endcase
    endfunction
    // Gate pattern that drives each sequential mode to one
    function automatic logic [3:0] seq_set(input logic [2:0] m);
        case (m)
            3'h3:    return 4'h1;
            3'h5:    return 4'hA;
            3'h7:    return 4'h3;
            default: return 4'h2;
        endcase
    endfunction
    task automatic wrap_up();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        rst_b = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        gate = 4'h0;
        n_fail = 0;
        compares = 0;
        void'($urandom(32'h4340));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(4'h0, d);
        `TB_CHK("ctrl reset", 8'h00, d)
        for (int m = 0; m < 8; m++)
        begin
            pol = 1'($urandom);
            wr_reg(4'h4, {7'h00, pol});
            wr_reg(4'h0, 8'hE0 | 8'(m));
            for (int i = 0; i < 6 && m < 3; i++)
            begin
                settle(4'($urandom));
                `TB_CHK("cell out", exp_out(3'(m), gate, pol), cell_out)
            end
            if (m >= 3)
            begin
                settle(seq_set(3'(m)));
                `TB_CHK("seq set", ~pol, cell_out)
                settle(4'h4);
                `TB_CHK("seq clear", pol, cell_out)
            end
            else
                settle(gate);
            st = (m < 3) ? exp_out(3'(m), gate, pol) : pol;
            rd_reg(4'h0, d);
            `TB_CHK("ctrl bits", 8'h80 | 8'(m), d & 8'hDF)
            `TB_CHK("out status", st, d[5])
        end
        wr_reg(4'h4, 8'h01);
        wr_reg(4'h0, 8'h02);
        for (int i = 0; i < 4; i++)
        begin
            settle(4'($urandom));
            `TB_CHK("off out", 1'b0, cell_out)
        end
        wr_reg(4'h4, 8'h00);
        wr_reg(4'h2, 8'h03);
        wr_reg(4'h0, 8'h92);
        settle(4'hF);
        `TB_CHK("irq rise", 1'b1, irq)
        rd_reg(4'h1, d);
        `TB_CHK("rise status", 8'h01, d)
        wr_reg(4'h1, 8'h01);
        settle(4'h0);
        `TB_CHK("no fall irq", 1'b0, irq)
        wr_reg(4'h0, 8'h8A);
        wr_reg(4'h2, 8'h01);
        settle(4'hF);
        settle(4'h0);
        rd_reg(4'h1, d);
        `TB_CHK("fall status", 8'h02, d)
        `TB_CHK("masked irq", 1'b0, irq)
        wr_reg(4'h2, 8'h03);
        wr_reg(4'hF, 8'hFF);
        rd_reg(4'hF, d);
        `TB_CHK("unmapped", 8'h00, d)
        `TB_CHK("irq unmask", 1'b1, irq)
        rd_reg(4'h2, d);
        `TB_CHK("mask read", 8'h03, d)
        rd_reg(4'h3, d);
        `TB_CHK("gate read", {4'h0, gate}, d)
        wr_reg(4'h1, 8'h03);
        settle(4'hF);
        `TB_CHK("irq cleared", 1'b0, irq)
        settle(4'h0);
        `TB_CHK("irq fall", 1'b1, irq)
        wr_reg(4'h4, 8'h01);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(4'h0, d);
        `TB_CHK("ctrl after reset", 8'h00, d)
        wr_reg(4'h0, 8'h80);
        settle(4'h0);
        `TB_CHK("invert kept", 1'b1, cell_out)
        wrap_up();
    end
endmodule
